// ---- shared/agc_pkg.sv ----
// Constants, types and helpers for the three-stage gain control block.
// Assumes a 20 MHz system clock and a byte-wide register port.
`default_nettype none
package agc_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_BATT      = 8'h02;
   localparam logic [7:0] ADDR_BOOST_V   = 8'h03;
   localparam logic [7:0] ADDR_BOOST_I   = 8'h04;
   localparam logic [7:0] ADDR_RATED_REL = 8'h07;
   localparam logic [7:0] ADDR_SHORT     = 8'h09;
   localparam logic [7:0] ADDR_CLIP      = 8'h0a;
   localparam logic [7:0] ADDR_STAGE_EN  = 8'h0c;
   localparam logic [7:0] ADDR_POWER     = 8'h0d;
   localparam logic [7:0] ADDR_STATUS    = 8'h0e;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int BATT_LIMIT_LSB  = 0;
   localparam int BATT_EN_BIT     = 2;
   localparam int BATT_THR_LSB    = 3;
   localparam int BOOST_V_LSB     = 0;
   localparam int BOOST_I_LSB     = 2;
   localparam int ATTACK_RATE_LSB = 2;
   localparam int RELEASE_LSB     = 5;
   localparam int CLIP_RATE_LSB   = 1;
   localparam int POWER_LSB       = 0;
   localparam logic [7:0] RST_CFG      = 8'h00;
   localparam logic [7:0] RST_STAGE_EN = 8'h07;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 50;
   localparam int TICK_NS        = 10000;
   localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
   localparam int HOLD_MS        = 10;
   localparam int HOLD_TICKS_DEF = HOLD_MS * 1000000 / TICK_NS;
   // Half-dB step intervals in ticks at selector zero
   localparam logic [15:0] CLIP_BASE    = 16'h0002;
   localparam logic [15:0] SHORT_BASE   = 16'h0008;
   localparam logic [15:0] RATED_BASE   = 16'h0010;
   localparam logic [15:0] RELEASE_BASE = 16'h0100;
   localparam logic [15:0] BATT_STEP    = 16'h0001;
   // Largest attenuation in half-dB steps
   localparam logic [4:0] MAX_ATTEN = 5'h1b;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic over_clip;
      logic over_short;
      logic over_rated;
      logic under_release;
   } level_type;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ATTACK  = 2'b01,
      ST_HOLD    = 2'b10,
      ST_RELEASE = 2'b11
   } state_type;
   // Interval for a stage from its base and rate selector
   function automatic logic [15:0] step_ticks(input logic [15:0] base,
                                              input logic [2:0]  sel);
      return base << sel;
   endfunction : step_ticks
endpackage : agc_pkg
`default_nettype wire

// ---- rtl/agc_core.sv ----
// Three-stage output gain control with battery limiter and config registers.
// Assumes comparator levels and zero-cross pulses synchronous to clk.
//
// How it works
// R01: Over threshold, attenuate in half-dB steps
// R02: Below release, raise gain in half-dB steps
// R03: Below general threshold, gain stays unchanged
// R04: Clip stage rate from 0x0a bits 2:1
// R05: Short-term stage rate from 0x09 bits 4:2
// R06: Rated stage rate from 0x07 bits 4:2
// R07: Attenuation steps only at zero crossings
// R08: Hold gain after dropping below release
// R09: Release starts only after hold elapses
// R10: Release rate from 0x07 bits 7:5
// R11: Release ends on re-attack or full gain
// R12: Each stage enabled separately
// R13: Low battery cuts gain quickly
// R14: Battery threshold from 0x02 bits 4:3
// R15: Battery peak limit from 0x02 bits 1:0
// R16: Battery limiter only when 0x02 bit 2
// R17: Boost voltage from 0x03 bits 4:0
// R18: Boost current limit from 0x04 bits 4:2
// R19: Output power target half to two watts
// R20: Attenuation never beyond 13.5 dB
// R21: Steps spaced by interval, then next zero
`timescale 1ns/1ps
`default_nettype none
module agc_core
#(
   parameter int TICK_CYCLES = agc_pkg::TICK_CYCLES_DEF,
   parameter int HOLD_TICKS  = agc_pkg::HOLD_TICKS_DEF
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Register port
   input  wire logic              reg_wr_en,
   input  wire logic              reg_rd_en,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   // Analog side monitors
   input  wire agc_pkg::level_type peak_level,
   input  wire logic              zero_cross,
   input  wire logic              batt_low,
   // Gain and analog settings
   output logic      [4:0]        gain_atten,
   output logic      [2:0]        stage_active,
   output logic      [4:0]        boost_voltage_sel,
   output logic      [2:0]        boost_current_sel,
   output logic      [1:0]        batt_threshold_sel,
   output logic      [1:0]        batt_peak_limit_sel,
   output logic      [3:0]        power_target_sel
);
   import agc_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] batt_cfg_q;
   logic [7:0] boost_v_q;
   logic [7:0] boost_i_q;
   logic [7:0] rated_rel_q;
   logic [7:0] short_q;
   logic [7:0] clip_q;
   logic [7:0] stage_en_q;
   logic [7:0] power_q;
   logic [7:0] rdata_q;
   logic [15:0] tick_cnt_q;
   logic        tick;
   logic [15:0] cnt_q;
   logic [4:0]  gain_atten_q;
   state_type   state_q;
   state_type   state_d;
   logic        clip_go;
   logic        short_go;
   logic        rated_go;
   logic        batt_act;
   logic        attack;
   logic [15:0] interval;
   logic        step_due;
   logic        step_dn;
   logic        step_up;

   // Host writes to configuration bytes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         batt_cfg_q  <= RST_CFG;
         boost_v_q   <= RST_CFG;
         boost_i_q   <= RST_CFG;
         rated_rel_q <= RST_CFG;
         short_q     <= RST_CFG;
         clip_q      <= RST_CFG;
         stage_en_q  <= RST_STAGE_EN;
         power_q     <= RST_CFG;
      end
      else if (reg_wr_en)
      begin
         case (reg_addr)
            ADDR_BATT:      batt_cfg_q  <= reg_wdata;
            ADDR_BOOST_V:   boost_v_q   <= reg_wdata;
            ADDR_BOOST_I:   boost_i_q   <= reg_wdata;
            ADDR_RATED_REL: rated_rel_q <= reg_wdata;
            ADDR_SHORT:     short_q     <= reg_wdata;
            ADDR_CLIP:      clip_q      <= reg_wdata;
            ADDR_STAGE_EN:  stage_en_q  <= reg_wdata;
            ADDR_POWER:     power_q     <= reg_wdata;
            default:        ;
         endcase
      end
   end

   // Registered read data, unmapped reads give zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= RST_CFG;
      else if (reg_rd_en)
      begin
         case (reg_addr)
            ADDR_BATT:      rdata_q <= batt_cfg_q;
            ADDR_BOOST_V:   rdata_q <= boost_v_q;
            ADDR_BOOST_I:   rdata_q <= boost_i_q;
            ADDR_RATED_REL: rdata_q <= rated_rel_q;
            ADDR_SHORT:     rdata_q <= short_q;
            ADDR_CLIP:      rdata_q <= clip_q;
            ADDR_STAGE_EN:  rdata_q <= stage_en_q;
            ADDR_POWER:     rdata_q <= power_q;
            ADDR_STATUS:    rdata_q <= {1'b0, state_q, gain_atten_q};
            default:        rdata_q <= RST_CFG;
         endcase
      end
   end

   // Settings passed to the analog side
   assign reg_rdata           = rdata_q;
   assign boost_voltage_sel   = boost_v_q[BOOST_V_LSB +: 5];   // R17
   assign boost_current_sel   = boost_i_q[BOOST_I_LSB +: 3];   // R18
   assign batt_threshold_sel  = batt_cfg_q[BATT_THR_LSB +: 2]; // R14
   assign batt_peak_limit_sel = batt_cfg_q[BATT_LIMIT_LSB +: 2]; // R15
   assign power_target_sel    = power_q[POWER_LSB +: 4];       // R19

   // ****************************************
   // Stage selection
   // ****************************************
   // Highest enabled stage whose threshold is exceeded wins
   assign clip_go  = stage_en_q[0] & peak_level.over_clip;            // R12
   assign short_go = stage_en_q[1] & peak_level.over_short & ~clip_go; // R12
   assign rated_go = stage_en_q[2] & peak_level.over_rated
                     & ~clip_go & ~short_go;                          // R12
   assign batt_act = batt_cfg_q[BATT_EN_BIT] & batt_low;              // R16
   assign attack   = clip_go | short_go | rated_go | batt_act;        // R03
   assign stage_active = {rated_go, short_go, clip_go};

   // Step interval of whichever activity is current
   always_comb
   begin
      if (batt_act)
         interval = BATT_STEP;                                         // R13
      else if (clip_go)
         interval = step_ticks(CLIP_BASE, {1'b0, clip_q[CLIP_RATE_LSB +: 2]}); // R04
      else if (short_go)
         interval = step_ticks(SHORT_BASE, short_q[ATTACK_RATE_LSB +: 3]); // R05
      else if (rated_go)
         interval = step_ticks(RATED_BASE, rated_rel_q[ATTACK_RATE_LSB +: 3]); // R06
      else
         interval = step_ticks(RELEASE_BASE, rated_rel_q[RELEASE_LSB +: 3]); // R10
   end

   // ****************************************
   // Timing
   // ****************************************
   // Tick divider giving the 10 us time base
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt_q <= 16'h0000;
      else if (tick)
         tick_cnt_q <= 16'h0000;
      else
         tick_cnt_q <= tick_cnt_q + 16'h0001;
   end
   assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

   // Interval and hold counter, restarts on state change or step
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 16'h0000;
      else if (state_d != state_q || step_dn || step_up)
         cnt_q <= 16'h0000;
      else if (tick && cnt_q != 16'hffff)
         cnt_q <= cnt_q + 16'h0001;
   end
   assign step_due = (cnt_q >= interval); // R21

   // ****************************************
   // Control sequence
   // ****************************************
   // Next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (attack)
               state_d = ST_ATTACK;
            else if (peak_level.under_release && gain_atten_q != 5'h00)
               state_d = ST_HOLD;                                      // R08
         ST_ATTACK:
            if (!attack)
               state_d = peak_level.under_release ? ST_HOLD : ST_IDLE; // R08
         ST_HOLD:
            if (attack)
               state_d = ST_ATTACK;
            else if (!peak_level.under_release)
               state_d = ST_IDLE;
            else if (cnt_q >= 16'(HOLD_TICKS))
               state_d = ST_RELEASE;                                   // R09
         ST_RELEASE:
            if (attack)
               state_d = ST_ATTACK;                                    // R11
            else if (!peak_level.under_release || gain_atten_q == 5'h00)
               state_d = ST_IDLE;                                      // R11
         default:
            state_d = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Step requests: cut only at a zero crossing, within the floor
   assign step_dn = (state_q == ST_ATTACK) && attack && step_due
                    && zero_cross && (gain_atten_q < MAX_ATTEN);       // R07 R20
   assign step_up = (state_q == ST_RELEASE) && !attack && step_due
                    && peak_level.under_release && (gain_atten_q != 5'h00); // R02 R11

   // Attenuation in half-dB steps
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         gain_atten_q <= 5'h00;
      else if (step_dn)
         gain_atten_q <= gain_atten_q + 5'h01;                         // R01
      else if (step_up)
         gain_atten_q <= gain_atten_q - 5'h01;                         // R02
   end
   assign gain_atten = gain_atten_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Attenuation never passes the floor
   a_atten_floor: assert property (gain_atten_q <= MAX_ATTEN) // R20
      else $error("attenuation past floor");
   // Gain moves by one half-dB step at a time
   a_half_step: assert property ( // R01
      (gain_atten_q != $past(gain_atten_q)) |->
      (gain_atten_q == $past(gain_atten_q) + 5'h01 ||
       gain_atten_q == $past(gain_atten_q) - 5'h01))
      else $error("gain moved more than one step");
   // Cuts land only on a zero crossing
   a_cut_at_zero: assert property ( // R07
      (gain_atten_q > $past(gain_atten_q)) |-> $past(zero_cross))
      else $error("gain cut away from zero crossing");
   // Idle leaves the gain alone
   a_idle_stable: assert property ( // R03
      (state_q == ST_IDLE) |=> (gain_atten_q == $past(gain_atten_q)))
      else $error("gain changed while idle");
   // Gain rises only in release
   a_rise_release: assert property ( // R09
      (gain_atten_q < $past(gain_atten_q)) |-> $past(state_q == ST_RELEASE))
      else $error("gain rose outside release");
   // Release waits for the whole hold time
   a_hold_wait: assert property ( // R09
      (state_q == ST_HOLD && state_d == ST_RELEASE) |->
      (cnt_q >= 16'(HOLD_TICKS)))
      else $error("release before hold time");
   // Release stops once the output is loud again
   a_release_stop: assert property ( // R11
      (state_q == ST_RELEASE && !peak_level.under_release) |=>
      (state_q != ST_RELEASE))
      else $error("release kept running");
   // A stage acts only while enabled
   a_stage_gate: assert property ( // R12
      (stage_active[0] |-> stage_en_q[0]) and
      (stage_active[1] |-> stage_en_q[1]) and
      (stage_active[2] |-> stage_en_q[2]))
      else $error("disabled stage acting");
   // Battery limiter acts only while enabled
   a_batt_gate: assert property ( // R16
      (batt_act |-> batt_cfg_q[BATT_EN_BIT]))
      else $error("battery limiter while disabled");
   // Cuts keep at least the selected interval apart
   a_step_spacing: assert property ( // R21
      (gain_atten_q > $past(gain_atten_q)) |-> $past(cnt_q >= interval))
      else $error("step before interval elapsed");
   // Every cut needs an acting stage or the battery limiter
   a_cut_needs_cause: assert property ( // R03
      (gain_atten_q > $past(gain_atten_q)) |-> $past(attack))
      else $error("gain cut with nothing acting");
   // An acting stage moves the sequence to attack on the next edge
   a_attack_entry: assert property ( // R01
      (attack && state_q != ST_ATTACK) |=> (state_q == ST_ATTACK))
      else $error("attack not entered");
   // Falling under release after a cut starts the hold
   a_hold_entry: assert property ( // R08
      (state_q == ST_ATTACK && !attack && peak_level.under_release) |=>
      (state_q == ST_HOLD))
      else $error("hold not entered");
   // No gain movement while holding
   a_hold_flat: assert property ( // R08
      (state_q == ST_HOLD) |=> (gain_atten_q == $past(gain_atten_q)))
      else $error("gain moved during hold");
   // A rise needs a quiet output under the release threshold
   a_rise_quiet: assert property ( // R02
      (gain_atten_q < $past(gain_atten_q)) |-> $past(peak_level.under_release && !attack))
      else $error("gain rose while loud");
   // Release ends once the initial gain is back
   a_rise_floor: assert property ( // R11
      (state_q == ST_RELEASE && gain_atten_q == 5'h00) |=>
      (state_q != ST_RELEASE))
      else $error("release ran past initial gain");

   // ****************************************
   // Cover points
   // ****************************************
   // Main scenarios the bench is expected to reach
   c_clip_attack: cover property (clip_go && step_dn);
   c_full_release: cover property (
      state_q == ST_RELEASE && step_up && gain_atten_q == 5'h01);
   c_batt_cut: cover property (batt_act && step_dn);
   c_short_step: cover property (short_go && step_dn);
   c_hold_done: cover property (state_q == ST_HOLD && state_d == ST_RELEASE);
endmodule : agc_core
`default_nettype wire

// ---- tb/host_model.sv ----
// Host side model: byte writes and reads on the block's register port.
// Assumes the bench clock; drives at the falling edge, one strobe per access.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   // Clock
   input  wire logic       clk,
   // Register port
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 8'hff;
      reg_wdata = 8'h5a;
   end

   // One byte write; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr

   // One byte read; data is taken once the read edge has passed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      d         = reg_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

// ---- tb/three_level_amp_gain_agc_tb.sv ----
// Self-checking bench for the gain control core, registers through the host model.
// Assumes short tick and hold parameters so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module three_level_amp_gain_agc_tb;
   import agc_pkg::*;
   typedef struct { logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; } row_type;
   logic       clk = 1'b0;
   logic       rst_n;
   logic       reg_wr_en, reg_rd_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   level_type  peak_level;
   logic       zero_cross, batt_low;
   logic [4:0] gain_atten, boost_voltage_sel;
   logic [2:0] stage_active, boost_current_sel;
   logic [1:0] batt_threshold_sel, batt_peak_limit_sel;
   logic [3:0] power_target_sel;
   int         bad_count = 0;
   int         comparisons = 0;
   int         cyc = 0;
   row_type    rows [10] = '{'{8'h02, 8'h1b, 8'h1b}, '{8'h03, 8'h15, 8'h15},
      '{8'h04, 8'h1c, 8'h1c}, '{8'h07, 8'h00, 8'h00}, '{8'h09, 8'h00, 8'h00},
      '{8'h0a, 8'h06, 8'h06}, '{8'h0c, 8'h07, 8'h07}, '{8'h0d, 8'h0a, 8'h0a},
      '{8'h0e, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}};

   // 20 MHz clock
   always #25 clk = ~clk;

   agc_core #(.TICK_CYCLES(2), .HOLD_TICKS(5)) i_agc_core (.clk(clk), .rst_n(rst_n),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .peak_level(peak_level),
      .zero_cross(zero_cross), .batt_low(batt_low), .gain_atten(gain_atten),
      .stage_active(stage_active), .boost_voltage_sel(boost_voltage_sel),
      .boost_current_sel(boost_current_sel), .batt_threshold_sel(batt_threshold_sel),
      .batt_peak_limit_sel(batt_peak_limit_sel), .power_target_sel(power_target_sel));

   host_model i_host_model (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Counts, verdict and stop
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // Compare one value
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask : cycles

   // Bounded wait for a gain value, then compare
   task automatic wait_gain(input logic [4:0] exp, input int lim);
      int n;
      n = 0;
      while (gain_atten !== exp && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      chk("gain_atten", {3'h0, exp}, {3'h0, gain_atten});
   endtask : wait_gain

   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         bad_count++;
         $display("mismatch timeout expected done seen running");
         end_of_test();
      end
   end

   // Main sequence
   initial
   begin
      rst_n      = 1'b0;
      peak_level = '0;
      zero_cross = 1'b0;
      batt_low   = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         i_host_model.rd(rows[i].addr, rd);
         chk("reset value", (rows[i].addr == ADDR_STAGE_EN) ? RST_STAGE_EN : RST_CFG, rd);
         i_host_model.wr(rows[i].addr, rows[i].wdata);
         i_host_model.rd(rows[i].addr, rd);
         chk("register", rows[i].rdata, rd);
      end
      chk("battery fields", 8'h0f, {4'h0, batt_threshold_sel, batt_peak_limit_sel});
      chk("boost voltage", 8'h15, {3'h0, boost_voltage_sel});
      chk("boost current", 8'h07, {5'h0, boost_current_sel});
      chk("power target", 8'h0a, {4'h0, power_target_sel});
      $display("test registers done");
      // Low battery: ignored while disabled, fast cut once enabled
      batt_low   = 1'b1;
      zero_cross = 1'b1;
      cycles(40);
      chk("gain limiter off", 8'h00, {3'h0, gain_atten});
      i_host_model.wr(ADDR_BATT, 8'h1f);
      wait_gain(5'd3, 30);
      batt_low = 1'b0;
      // Reset in mid-run
      rst_n = 1'b0;
      cycles(2);
      chk("gain in reset", 8'h00, {3'h0, gain_atten});
      rst_n = 1'b1;
      i_host_model.rd(ADDR_STAGE_EN, rd);
      chk("stage enable after reset", RST_STAGE_EN, rd);
      $display("test battery and reset done");
      // Clip stage at rate select 3: steps wait for a zero crossing
      zero_cross = 1'b0;
      i_host_model.wr(ADDR_CLIP, 8'h06);
      peak_level = 4'h8;
      cycles(40);
      chk("gain no zero crossing", 8'h00, {3'h0, gain_atten});
      chk("active stages", 8'h01, {5'h0, stage_active});
      zero_cross = 1'b1;
      wait_gain(5'd1, 4);
      cycles(25);
      chk("gain within interval", 8'h01, {3'h0, gain_atten});
      wait_gain(5'd2, 15);
      i_host_model.wr(ADDR_CLIP, 8'h00);
      wait_gain(5'd27, 200);
      cycles(20);
      chk("gain floor", 8'h1b, {3'h0, gain_atten});
      $display("test clip attack done");
      // Hold, slow release, stop, then full release
      i_host_model.wr(ADDR_RATED_REL, 8'h20);
      peak_level = 4'h1;
      cycles(4);
      i_host_model.rd(ADDR_STATUS, rd);
      chk("status in hold", 8'h5b, rd);
      cycles(600);
      chk("gain before release step", 8'h1b, {3'h0, gain_atten});
      wait_gain(5'd26, 500);
      peak_level = 4'h0;
      cycles(1100);
      chk("gain release stopped", 8'h1a, {3'h0, gain_atten});
      i_host_model.wr(ADDR_RATED_REL, 8'h00);
      peak_level = 4'h1;
      wait_gain(5'd0, 14000);
      cycles(600);
      i_host_model.rd(ADDR_STATUS, rd);
      chk("status after release", 8'h00, rd);
      $display("test release done");
      // Separate stage enables
      peak_level = 4'he;
      i_host_model.wr(ADDR_STAGE_EN, 8'h06);
      cycles(2);
      chk("short stage only", 8'h02, {5'h0, stage_active});
      i_host_model.wr(ADDR_STAGE_EN, 8'h04);
      cycles(2);
      chk("rated stage only", 8'h04, {5'h0, stage_active});
      wait_gain(5'd1, 40);
      // Short stage at rate select 2 takes over from the rated stage
      i_host_model.wr(ADDR_SHORT, 8'h08);
      i_host_model.wr(ADDR_STAGE_EN, 8'h02);
      cycles(40);
      chk("gain within short interval", 8'h01, {3'h0, gain_atten});
      wait_gain(5'd2, 30);
      $display("test stage enables done");
      end_of_test();
   end
endmodule : three_level_amp_gain_agc_tb
`default_nettype wire
